// ### verilog/frame_access_map.svh
// frame access: offsets, field positions, reset values and counts
// assumes inclusion by bare name from the design files
`ifndef FRAME_ACCESS_MAP_SVH
`define FRAME_ACCESS_MAP_SVH
// page offsets of the receive and transmit areas
`define RX_STAT_OFS   12'h400
`define RX_LEN_OFS    12'h402
`define RX_DATA_OFS   12'h404
`define TX_DATA_OFS   12'hA00
// page registers
`define IO_BASE_OFS   12'h020
`define MEM_LO_OFS    12'h02C
`define MEM_HI_OFS    12'h02E
`define BOOT_LO_OFS   12'h030
`define BOOT_HI_OFS   12'h032
`define RX_CFG_OFS    12'h102
`define BUS_CTL_OFS   12'h116
`define ISQ_OFS       12'h120
`define RX_EVENT_OFS  12'h124
// i/o port offsets from the i/o base
`define IO_DATA_PORT  4'h0
`define IO_ISQ_PORT   4'h8
`define IO_PTR_PORT   4'hA
`define IO_PDATA_PORT 4'hC
// field positions
`define MEM_EN_BIT    10
`define CRC_EN_BIT    11
`define SKIP_BIT      6
`define AUTO_INC_BIT  15
// reset values and counts
`define IO_BASE_RST   12'h030
`define MBASE_RST     8'h0D
`define BBASE_RST     8'h0C
`define RANDOM_BYTES  16'h0076
`define HDR_BYTES     16'h0004
`define CRC_BYTES     16'h0004
`endif

// ### verilog/frame_pkg.sv
// frame access: shared types
// assumes nothing of its surroundings
package frame_pkg;
	typedef enum logic [1:0] {RD_IDLE, RD_ADDR, RD_DATA} rd_state_t;
	typedef logic [15:0] word_t;
endpackage

// ### verilog/rx_access_if.sv
// rx_access_if: host bus side to receive frame tracker
// assumes both ends run on one clock
`timescale 1ns/1ps
interface rx_access_if;
	logic                new_frame;
	frame_pkg::word_t    new_status;
	frame_pkg::word_t    new_len;
	logic [10:0]         new_base;
	logic                crc_en;
	logic                rd_done;
	frame_pkg::word_t    rd_off;
	logic [1:0]          rd_bytes;
	logic                ev_read;
	logic                skip;
	logic                valid;
	frame_pkg::word_t    status;
	frame_pkg::word_t    length;
	logic [10:0]         base;
	frame_pkg::word_t    ptr;
	frame_pkg::word_t    event_w;
	logic                release_p;
	modport bus (output new_frame, new_status, new_len, new_base, crc_en, rd_done, rd_off,
		rd_bytes, ev_read, skip, input valid, status, length, base, ptr, event_w, release_p);
	modport trk (input new_frame, new_status, new_len, new_base, crc_en, rd_done, rd_off,
		rd_bytes, ev_read, skip, output valid, status, length, base, ptr, event_w, release_p);
endinterface

// ### verilog/rx_frame_tracker.sv
// rx_frame_tracker: current receive frame, read pointer, event register
// assumes new frames arrive only after the previous one was released
`timescale 1ns/1ps
`include "frame_access_map.svh"
module rx_frame_tracker (
	input wire logic clk,
	input wire logic rst,
	rx_access_if.trk ra
);
	logic             valid_q;
	logic             rel_q;
	frame_pkg::word_t status_q;
	frame_pkg::word_t len_q;
	frame_pkg::word_t ptr_q;
	frame_pkg::word_t event_q;
	logic [10:0]      base_q;
	frame_pkg::word_t len_eff;
	frame_pkg::word_t nxt;
	logic             done;
	logic             drop;

	assign len_eff = ra.crc_en ? len_q : len_q - `CRC_BYTES;
	assign nxt = ra.rd_off + {14'h0000, ra.rd_bytes};
	assign done = ra.rd_done && valid_q && (nxt >= len_eff + `HDR_BYTES);
	assign drop = valid_q && (ra.ev_read || ra.skip || done);

	// one frame held at a time; a new frame wins over a drop
	always_ff @(posedge clk) begin
		if (rst) begin
			valid_q <= 1'b0;
		end else if (ra.new_frame) begin
			valid_q <= 1'b1;
		end else if (drop) begin
			valid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rel_q <= 1'b0;
		end else begin
			rel_q <= drop;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			event_q <= 16'h0000;
		end else if (ra.new_frame) begin
			event_q <= ra.new_status;
		end else if (ra.ev_read) begin
			event_q <= 16'h0000;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_q    <= 16'h0000;
			status_q <= 16'h0000;
			len_q    <= 16'h0000;
			base_q   <= 11'h000;
		end else if (ra.new_frame) begin
			ptr_q    <= 16'h0000;
			status_q <= ra.new_status;
			len_q    <= ra.new_len;
			base_q   <= ra.new_base;
		end else if (ra.rd_done && valid_q) begin
			ptr_q <= nxt;
		end
	end

	assign ra.valid     = valid_q;
	assign ra.status    = status_q;
	assign ra.length    = len_eff;
	assign ra.base      = base_q;
	assign ra.ptr       = ptr_q;
	assign ra.event_w   = event_q;
	assign ra.release_p = rel_q;

	a_event_clear: assert property (@(posedge clk) disable iff (rst)
		ra.ev_read && !ra.new_frame |=> event_q == 16'h0000)
		else $error("event register not cleared by its read");
	a_event_mirror: assert property (@(posedge clk) disable iff (rst)
		ra.new_frame |=> event_q == status_q)
		else $error("event register differs from status");
	a_release_read: assert property (@(posedge clk) disable iff (rst)
		valid_q && ra.ev_read && !ra.new_frame |=> !valid_q && rel_q)
		else $error("event read did not release frame");
	a_skip_drop: assert property (@(posedge clk) disable iff (rst)
		valid_q && ra.skip && !ra.new_frame |=> !valid_q && rel_q ##1 !rel_q)
		else $error("skip did not release frame");
	a_len_crc: assert property (@(posedge clk) disable iff (rst)
		ra.new_frame ##1 !ra.crc_en |-> ra.length == $past(ra.new_len) - 16'h0004)
		else $error("length counts crc while crc buffering off");
endmodule // rx_frame_tracker

// ### verilog/frame_buffer_host_access.sv
// frame_buffer_host_access: isa-style host access to the frame buffer
// assumes a synchronous buffer ram with one cycle read latency
// and receive/transmit engines on SYS_CLK
`timescale 1ns/1ps
`include "frame_access_map.svh"
// Contract
// - buffer shared; one receive frame and one transmit frame visible.
// - i/o data port returns status, length, then frame bytes in turn.
// - memory mode receive block: status 0400h, length 0402h, data 0404h.
// - transmit bytes written sequentially from 0A00h by block moves.
// - first 118 frame bytes random by even word reads; later sequential.
// - event register at 0124h mirrors status, clears on read.
// - length includes crc only when crc buffering is enabled.
// - event read, direct or via queue, releases the current frame.
// - skip command or full read also withdraws the frame.
// - word and byte transfers in both spaces over a 16-bit path.
// - memory mode maps the page into a 4 KB window at X000h.
// - reset leaves i/o mode; memory mode reaches every register.
// - memory cycles finish with no added wait states.
// - memory access needs address in range, chip select low, strobe.
// - page read/write and boot rom read through memory cycles.
module frame_buffer_host_access (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic [19:0] SA,
	input  wire logic        SBHE_N,
	input  wire logic [15:0] SD_IN,
	output logic      [15:0] SD_OUT,
	output logic             SD_OE_N,
	input  wire logic        MEMORY_READ_STROBE_N,
	input  wire logic        MEMORY_WRITE_STROBE_N,
	input  wire logic        IOR_N,
	input  wire logic        IOW_N,
	input  wire logic        AEN,
	input  wire logic        CHIP_SEL_N,
	output logic             BOOT_ROM_CS_N,
	output logic      [10:0] BUF_ADDR,
	output logic      [15:0] BUF_WDATA,
	output logic      [1:0]  BUF_BE,
	output logic             BUF_WE,
	input  wire logic [15:0] BUF_RDATA,
	input  wire logic        RX_NEW,
	input  wire logic [15:0] RX_STATUS,
	input  wire logic [15:0] RX_LEN,
	input  wire logic [10:0] RX_BASE,
	output logic             RX_RELEASE,
	input  wire logic        TX_NEW,
	input  wire logic [10:0] TX_BASE,
	output logic      [15:0] TX_COUNT,
	output logic             MEM_MODE
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [42:0] s1_q;
	logic [42:0] s2_q;
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			s1_q <= 43'h7FFFFFFFFFF;
			s2_q <= 43'h7FFFFFFFFFF;
		end else begin
			s1_q <= {SA, SBHE_N, SD_IN, MEMORY_READ_STROBE_N, MEMORY_WRITE_STROBE_N, IOR_N, IOW_N, AEN, CHIP_SEL_N};
			s2_q <= s1_q;
		end
	end
	logic [19:0] a;
	logic [15:0] sd;
	logic        bhe_n, memory_read_strobe_n, memory_write_strobe_n, ior_n, iow_n, aen, cs_n;
	assign a      = s2_q[42:23];
	assign bhe_n  = s2_q[22];
	assign sd     = s2_q[21:6];
	assign memory_read_strobe_n = s2_q[5];
	assign memory_write_strobe_n = s2_q[4];
	assign ior_n  = s2_q[3];
	assign iow_n  = s2_q[2];
	assign aen    = s2_q[1];
	assign cs_n   = s2_q[0];

	// ----------------------------------------
	// registers and tracker
	// ----------------------------------------
	logic [11:0]      iobase_q;
	logic [7:0]       mbase_q;
	logic [7:0]       bbase_q;
	frame_pkg::word_t receive_configuration_register_q;
	frame_pkg::word_t bus_control_register_q;
	frame_pkg::word_t pp_q;
	logic             skip_q;
	rx_access_if ra ();
	rx_frame_tracker u_trk (
		.clk (SYS_CLK),
		.rst (RST),
		.ra  (ra.trk)
	);
	assign ra.new_frame  = RX_NEW;
	assign ra.new_status = RX_STATUS;
	assign ra.new_len    = RX_LEN;
	assign ra.new_base   = RX_BASE;
	assign ra.crc_en     = receive_configuration_register_q[`CRC_EN_BIT];
	assign ra.skip       = skip_q;
	assign RX_RELEASE    = ra.release_p;
	assign MEM_MODE      = bus_control_register_q[`MEM_EN_BIT];

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	logic mem_hit, mem_rd, mem_wr, io_hit, io_rd, io_wr, rd_any, acc, acc_q;
	logic word, start, fin;
	assign mem_hit = MEM_MODE && (a[19:12] == mbase_q) && !cs_n;
	assign mem_rd  = mem_hit && !memory_read_strobe_n;
	assign mem_wr  = mem_hit && !memory_write_strobe_n;
	assign io_hit  = !aen && (a[15:4] == iobase_q);
	assign io_rd   = io_hit && !ior_n;
	assign io_wr   = io_hit && !iow_n;
	assign rd_any  = mem_rd || io_rd;
	assign acc     = rd_any || mem_wr || io_wr;
	assign word    = !bhe_n && !a[0];
	assign start   = acc && !acc_q;
	assign fin     = !acc && acc_q;

	// receive offset: random inside the first bytes, else sequential
	frame_pkg::word_t rel, r;
	logic             rxr, rnd;
	assign rel = {4'h0, a[11:0]} - {4'h0, `RX_STAT_OFS};
	assign rnd = mem_rd && word && (rel < `HDR_BYTES + `RANDOM_BYTES);
	assign r   = rnd ? rel : ra.ptr;
	assign rxr = mem_rd ? (a[11:0] >= `RX_STAT_OFS && a[11:0] < `TX_DATA_OFS) :
		(io_rd && a[3:0] == `IO_DATA_PORT);

	function automatic frame_pkg::word_t lane(input frame_pkg::word_t w, input logic wd,
		input logic hi);
		logic [7:0] b;
		b = hi ? w[15:8] : w[7:0];
		lane = wd ? w : {b, b};
	endfunction

	function automatic frame_pkg::word_t page_rd(input logic [11:0] p);
		if (p == `IO_BASE_OFS) begin
			page_rd = {4'h0, iobase_q};
		end else if (p == `MEM_LO_OFS) begin
			page_rd = {mbase_q[3:0], 12'h000};
		end else if (p == `MEM_HI_OFS) begin
			page_rd = {12'h000, mbase_q[7:4]};
		end else if (p == `BOOT_LO_OFS) begin
			page_rd = {bbase_q[3:0], 12'h000};
		end else if (p == `BOOT_HI_OFS) begin
			page_rd = {12'h000, bbase_q[7:4]};
		end else if (p == `RX_CFG_OFS) begin
			page_rd = receive_configuration_register_q;
		end else if (p == `BUS_CTL_OFS) begin
			page_rd = bus_control_register_q;
		end else if (p == `ISQ_OFS || p == `RX_EVENT_OFS) begin
			page_rd = ra.event_w;
		end else begin
			page_rd = 16'h0000;
		end
	endfunction

	// ----------------------------------------
	// cycle capture
	// ----------------------------------------
	logic [19:0]      ca_q;
	logic             cm_q, cw_q, cwd_q, rxr_q, evr_q;
	frame_pkg::word_t r_q, wd_q;
	logic [11:0]      rpa;
	assign rpa = mem_rd ? a[11:0] : pp_q[11:0];
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			acc_q <= 1'b0;
			ca_q  <= 20'h00000;
			cm_q  <= 1'b0;
			cw_q  <= 1'b0;
			cwd_q <= 1'b0;
			rxr_q <= 1'b0;
			evr_q <= 1'b0;
			r_q   <= 16'h0000;
			wd_q  <= 16'h0000;
		end else begin
			acc_q <= acc;
			if (acc) begin
				wd_q <= sd;
			end
			if (start) begin
				ca_q  <= a;
				cm_q  <= mem_rd || mem_wr;
				cw_q  <= mem_wr || io_wr;
				cwd_q <= word;
				rxr_q <= rxr;
				r_q   <= r;
				evr_q <= (io_rd && a[3:0] == `IO_ISQ_PORT) || ((mem_rd ||
					(io_rd && a[3:0] == `IO_PDATA_PORT)) &&
					(rpa == `ISQ_OFS || rpa == `RX_EVENT_OFS));
			end
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	frame_pkg::rd_state_t st_q;
	frame_pkg::word_t     sd_q, rfo;
	logic                 fetch;
	assign rfo   = r - `HDR_BYTES;
	assign fetch = rxr && ra.valid && (r >= `HDR_BYTES);
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			st_q <= frame_pkg::RD_IDLE;
		end else begin
			case (st_q)
				frame_pkg::RD_IDLE: begin
					if (start && fetch) begin
						st_q <= frame_pkg::RD_ADDR;
					end
				end
				frame_pkg::RD_ADDR: begin
					st_q <= frame_pkg::RD_DATA;
				end
				default: begin
					st_q <= frame_pkg::RD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sd_q <= 16'h0000;
		end else if (st_q == frame_pkg::RD_DATA) begin
			sd_q <= lane(BUF_RDATA, cwd_q, r_q[0]);
		end else if (start && rd_any) begin
			if (rxr && !ra.valid) begin
				sd_q <= 16'h0000;
			end else if (rxr && r < 16'h0002) begin
				sd_q <= lane(ra.status, word, r[0]);
			end else if (rxr && r < `HDR_BYTES) begin
				sd_q <= lane(ra.length, word, r[0]);
			end else if (rxr) begin
				sd_q <= sd_q;
			end else if (mem_rd) begin
				sd_q <= page_rd(a[11:0]);
			end else if (a[3:0] == `IO_PTR_PORT) begin
				sd_q <= pp_q;
			end else if (a[3:0] == `IO_PDATA_PORT || a[3:0] == `IO_ISQ_PORT) begin
				sd_q <= page_rd(a[3:0] == `IO_ISQ_PORT ? `ISQ_OFS : pp_q[11:0]);
			end else begin
				sd_q <= 16'h0000;
			end
		end
	end
	assign SD_OUT = sd_q;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SD_OE_N       <= 1'b1;
			BOOT_ROM_CS_N <= 1'b1;
		end else begin
			SD_OE_N       <= !rd_any;
			BOOT_ROM_CS_N <= !(!mem_hit && !cs_n && !memory_read_strobe_n && a[19:12] == bbase_q);
		end
	end

	// ----------------------------------------
	// end of cycle effects
	// ----------------------------------------
	logic [11:0] wpa;
	logic        txw, pgw, rdfin;
	assign wpa   = cm_q ? ca_q[11:0] : pp_q[11:0];
	assign txw   = fin && cw_q && (cm_q ? ca_q[11:0] >= `TX_DATA_OFS :
		ca_q[3:0] == `IO_DATA_PORT);
	assign pgw   = fin && cw_q && (cm_q ? ca_q[11:0] < `RX_STAT_OFS :
		ca_q[3:0] == `IO_PDATA_PORT);
	assign rdfin = fin && !cw_q;
	assign ra.rd_done  = rdfin && rxr_q;
	assign ra.rd_off   = r_q;
	assign ra.rd_bytes = cwd_q ? 2'h2 : 2'h1;
	assign ra.ev_read  = rdfin && evr_q;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			iobase_q <= `IO_BASE_RST;
			mbase_q  <= `MBASE_RST;
			bbase_q  <= `BBASE_RST;
			receive_configuration_register_q  <= 16'h0000;
			bus_control_register_q <= 16'h0000;
			skip_q   <= 1'b0;
		end else begin
			skip_q <= pgw && wpa == `RX_CFG_OFS && wd_q[`SKIP_BIT];
			if (pgw) begin
				if (wpa == `IO_BASE_OFS) begin
					iobase_q <= wd_q[11:0];
				end else if (wpa == `MEM_LO_OFS) begin
					mbase_q[3:0] <= wd_q[15:12];
				end else if (wpa == `MEM_HI_OFS) begin
					mbase_q[7:4] <= wd_q[3:0];
				end else if (wpa == `BOOT_LO_OFS) begin
					bbase_q[3:0] <= wd_q[15:12];
				end else if (wpa == `BOOT_HI_OFS) begin
					bbase_q[7:4] <= wd_q[3:0];
				end else if (wpa == `RX_CFG_OFS) begin
					receive_configuration_register_q <= wd_q & ~(16'h0001 << `SKIP_BIT);
				end else if (wpa == `BUS_CTL_OFS) begin
					bus_control_register_q <= wd_q;
				end
			end
		end
	end

	// page pointer with optional auto-increment
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pp_q <= 16'h3000;
		end else if (fin && !cm_q && cw_q && ca_q[3:0] == `IO_PTR_PORT) begin
			pp_q <= {wd_q[15], 3'h3, wd_q[11:0]};
		end else if (fin && !cm_q && ca_q[3:0] == `IO_PDATA_PORT && pp_q[`AUTO_INC_BIT]) begin
			pp_q <= {pp_q[15:12], pp_q[11:0] + 12'h002};
		end
	end

	// ----------------------------------------
	// buffer port: receive fetch and transmit fill
	// ----------------------------------------
	frame_pkg::word_t tx_ptr_q;
	logic [7:0]       tb;
	assign tb = ca_q[0] ? wd_q[15:8] : wd_q[7:0];
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			BUF_ADDR  <= 11'h000;
			BUF_WDATA <= 16'h0000;
			BUF_BE    <= 2'h0;
			BUF_WE    <= 1'b0;
			tx_ptr_q  <= 16'h0000;
		end else begin
			BUF_WE <= 1'b0;
			if (TX_NEW) begin
				tx_ptr_q <= 16'h0000;
			end else if (txw) begin
				BUF_ADDR  <= TX_BASE + tx_ptr_q[11:1];
				BUF_WE    <= 1'b1;
				BUF_WDATA <= cwd_q ? wd_q : {tb, tb};
				BUF_BE    <= cwd_q ? 2'h3 : (tx_ptr_q[0] ? 2'h2 : 2'h1);
				tx_ptr_q  <= tx_ptr_q + (cwd_q ? 16'h0002 : 16'h0001);
			end else if (start && fetch) begin
				BUF_ADDR <= ra.base + rfo[11:1];
			end
		end
	end
	assign TX_COUNT = tx_ptr_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_rx_fetch;
		st_q == frame_pkg::RD_IDLE && start && fetch && !TX_NEW;
	endsequence
	sequence s_fetch_done;
		st_q == frame_pkg::RD_ADDR ##1 st_q == frame_pkg::RD_DATA;
	endsequence
	a_rx_fetch: assert property (@(posedge SYS_CLK) disable iff (RST)
		s_rx_fetch |=> (BUF_ADDR == $past(ra.base + rfo[11:1])) && !BUF_WE)
		else $error("receive fetch address wrong");
	a_no_wait: assert property (@(posedge SYS_CLK) disable iff (RST)
		s_rx_fetch |=> s_fetch_done ##1 st_q == frame_pkg::RD_IDLE)
		else $error("receive read took extra cycles");
	a_io_default: assert property (@(posedge SYS_CLK)
		RST |=> !MEM_MODE && SD_OE_N)
		else $error("not in i/o mode after reset");
	a_drive_read: assert property (@(posedge SYS_CLK) disable iff (RST)
		!SD_OE_N |-> $past(rd_any))
		else $error("data driven outside a read");
	a_tx_commit: assert property (@(posedge SYS_CLK) disable iff (RST)
		txw && !TX_NEW |=> BUF_WE && BUF_ADDR == $past(TX_BASE + tx_ptr_q[11:1]))
		else $error("transmit write not committed");
	a_window_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
		cs_n || !MEM_MODE |=> !(cm_q && $rose(acc_q)))
		else $error("memory cycle taken without select");
endmodule // frame_buffer_host_access

// ### dv/buf_ram_model.sv
// buf_ram_model: frame buffer ram seen behind the host access block
// assumes one clock and a registered read of one cycle
`timescale 1ns/1ps
module buf_ram_model (
	input  wire logic        clk,
	input  wire logic [10:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic [1:0]  be,
	input  wire logic        we,
	output logic      [15:0] rdata
);
	logic [15:0] mem [0:2047];

	// one store shared by receive and transmit frames
	always @(posedge clk) begin
		if (we && be[0])
			mem[addr][7:0] <= wdata[7:0];
		if (we && be[1])
			mem[addr][15:8] <= wdata[15:8];
		rdata <= mem[addr];
	end
endmodule // buf_ram_model

// ### dv/frame_buffer_host_access_tb.sv
// frame_buffer_host_access_tb: host bus scenarios against the frame access block
// assumes window at D000h and i/o base at 300h after reset
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module frame_buffer_host_access_tb;
	logic        sys_clk    = 1'b0;
	logic        rst        = 1'b1;
	logic [19:0] sa         = 20'h00000;
	logic [15:0] sd_in      = 16'h0000;
	logic [3:0]  strb_n     = 4'hF;
	logic        chip_sel_n = 1'b0;
	logic        bhe_n      = 1'b0;
	logic        boot_cs_n, boot_seen;
	logic        rx_new     = 1'b0;
	logic [15:0] rx_status  = 16'h0000;
	logic [15:0] rx_len     = 16'h0000;
	logic        tx_new     = 1'b0;
	logic [10:0] tx_base    = 11'h000;
	logic [15:0] sd_out, tx_count, buf_wdata, buf_rdata, q;
	logic [10:0] buf_addr;
	logic [1:0]  buf_be;
	logic        sd_oe_n, buf_we, rx_release, mem_mode, rel_seen, oe_seen;
	int          fails, checks_done, cyc;

	// ----------------------------------------
	// clock, design and buffer
	// ----------------------------------------
	always #10 sys_clk = ~sys_clk;

	frame_buffer_host_access i_frame_buffer_host_access (.SYS_CLK(sys_clk), .RST(rst),
		.SA(sa), .SBHE_N(bhe_n), .SD_IN(sd_in), .SD_OUT(sd_out), .SD_OE_N(sd_oe_n),
		.MEMORY_READ_STROBE_N(strb_n[3]), .MEMORY_WRITE_STROBE_N(strb_n[2]), .IOR_N(strb_n[1]), .IOW_N(strb_n[0]),
		.AEN(1'b0), .CHIP_SEL_N(chip_sel_n), .BOOT_ROM_CS_N(boot_cs_n), .BUF_ADDR(buf_addr),
		.BUF_WDATA(buf_wdata), .BUF_BE(buf_be), .BUF_WE(buf_we), .BUF_RDATA(buf_rdata),
		.RX_NEW(rx_new), .RX_STATUS(rx_status), .RX_LEN(rx_len), .RX_BASE(11'h010),
		.RX_RELEASE(rx_release), .TX_NEW(tx_new), .TX_BASE(tx_base), .TX_COUNT(tx_count),
		.MEM_MODE(mem_mode));

	buf_ram_model i_buf_ram_model (.clk(sys_clk), .addr(buf_addr), .wdata(buf_wdata),
		.be(buf_be), .we(buf_we), .rdata(buf_rdata));

	// sticky flags and the hang limit
	always @(posedge sys_clk) begin
		cyc++;
		if (rx_release)
			rel_seen <= 1'b1;
		if (!sd_oe_n)
			oe_seen <= 1'b1;
		if (!boot_cs_n)
			boot_seen <= 1'b1;
		if (cyc == 6000) begin
			fails++;
			summarize();
		end
	end

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// kind 0 memory read, 1 memory write, 2 io read, 3 io write
	// word or byte cycles only, never double words
	task automatic bus(input logic [1:0] k, input logic [19:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		sa = a;
		sd_in = d;
		oe_seen = 1'b0;
		boot_seen = 1'b0;
		strb_n = ~(4'b1000 >> k);
		repeat (8) @(negedge sys_clk);
		q = sd_out;
		strb_n = 4'hF;
		repeat (5) @(negedge sys_clk);
	endtask

	task automatic mrd(input logic [11:0] o, input logic [15:0] e);
		bus(2'h0, {8'h0D, o}, 16'h0000);
		`CHK(q, e)
	endtask

	task automatic mwr(input logic [11:0] o, input logic [15:0] d);
		bus(2'h1, {8'h0D, o}, d);
	endtask

	task automatic ird(input logic [3:0] p, input logic [15:0] e);
		bus(2'h2, {16'h0030, p}, 16'h0000);
		`CHK(q, e)
	endtask

	task automatic iwr(input logic [3:0] p, input logic [15:0] d);
		bus(2'h3, {16'h0030, p}, d);
	endtask

	task automatic new_frame(input logic [15:0] st, input logic [15:0] len);
		@(negedge sys_clk);
		rx_status = st;
		rx_len = len;
		rx_new = 1'b1;
		@(negedge sys_clk);
		rx_new = 1'b0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_io_rx();
		`CHK(mem_mode, 1'b0)
		iwr(4'hA, 16'h0102);
		iwr(4'hC, 16'h0800);
		new_frame(16'h5A01, 16'h000C);
		ird(4'h0, 16'h5A01);
		ird(4'h0, 16'h000C);
		ird(4'h0, 16'hA000);
		ird(4'h0, 16'hA001);
		bhe_n = 1'b1;
		ird(4'h0, 16'h0202);
		ird(4'h0, 16'hA0A0);
		bhe_n = 1'b0;
	endtask

	task automatic t_mem_rx();
		iwr(4'hA, 16'h0116);
		iwr(4'hC, 16'h0400);
		`CHK(mem_mode, 1'b1)
		mrd(12'h400, 16'h5A01);
		mrd(12'h402, 16'h000C);
		mrd(12'h40A, 16'hA003);
		mrd(12'h406, 16'hA001);
		mwr(12'h400, 16'hFFFF);
		mrd(12'h400, 16'h5A01);
		mrd(12'hA00, 16'h0000);
		chip_sel_n = 1'b1;
		bus(2'h0, 20'h0D400, 16'h0000);
		`CHK(oe_seen, 1'b0)
		chip_sel_n = 1'b0;
		bus(2'h0, 20'h0C000, 16'h0000);
		`CHK(boot_seen, 1'b1)
	endtask

	task automatic t_release();
		rel_seen = 1'b0;
		mrd(12'h124, 16'h5A01);
		`CHK(rel_seen, 1'b1)
		mrd(12'h124, 16'h0000);
		mrd(12'h400, 16'h0000);
	endtask

	task automatic t_full_read();
		mwr(12'h102, 16'h0000);
		new_frame(16'h5A02, 16'h0008);
		mrd(12'h402, 16'h0004);
		rel_seen = 1'b0;
		mrd(12'h404, 16'hA000);
		`CHK(rel_seen, 1'b0)
		mrd(12'h406, 16'hA001);
		`CHK(rel_seen, 1'b1)
	endtask

	task automatic t_skip();
		new_frame(16'h5A03, 16'h0008);
		rel_seen = 1'b0;
		mwr(12'h102, 16'h0040);
		`CHK(rel_seen, 1'b1)
		mrd(12'h400, 16'h0000);
	endtask

	task automatic t_tx();
		@(negedge sys_clk);
		tx_base = 11'h100;
		tx_new = 1'b1;
		@(negedge sys_clk);
		tx_new = 1'b0;
		mwr(12'hA00, 16'hBEEF);
		mwr(12'hA02, 16'hCAFE);
		`CHK(tx_count, 16'h0004)
		`CHK(i_buf_ram_model.mem[256], 16'hBEEF)
		`CHK(i_buf_ram_model.mem[257], 16'hCAFE)
		bhe_n = 1'b1;
		mwr(12'hA04, 16'h0011);
		mwr(12'hA05, 16'h2200);
		bhe_n = 1'b0;
		`CHK(tx_count, 16'h0006)
		`CHK(i_buf_ram_model.mem[258], 16'h2211)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		fails = 0;
		checks_done = 0;
		cyc = 0;
		rel_seen = 1'b0;
		oe_seen = 1'b0;
		boot_seen = 1'b0;
		for (int i = 0; i < 16; i++)
			i_buf_ram_model.mem[16 + i] = 16'hA000 + 16'(i);
		repeat (12) @(negedge sys_clk);
		rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		t_io_rx();
		t_mem_rx();
		t_release();
		t_full_read();
		t_skip();
		t_tx();
		summarize();
	end
endmodule // frame_buffer_host_access_tb
